/* core/cold_guard.sv */
`timescale 1ns/1ps
module cold_guard #(
  parameter int UNIT_CYCLES = cold_guard_pkg::UNIT_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_write_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [15:0] cmd_wdata_i,
  input  wire logic        clear_faults_i,
  input  wire logic        clear_status_i,
  input  wire logic        ctrl_pin_i,
  input  wire logic        operation_on_i,
  input  wire logic [15:0] temp_i,
  output logic [15:0]      rdata_o,
  output logic             rvalid_o,
  output logic             cmd_err_o,
  output logic             power_enable_o,
  output logic             warn_flag_o,
  output logic             fault_flag_o
);

  localparam int CW = $clog2(cold_guard_pkg::MAX_UNITS * UNIT_CYCLES + 1);

  // A one-cycle delay would underflow the reload count between restart attempts
  if (UNIT_CYCLES < 2) begin : g_bad_unit
    $error("UNIT_CYCLES must be at least two");
  end

  cold_guard_pkg::guard_state_t state_q, state_d;
  logic [15:0]   warn_thr_q, warn_thr_d;
  logic [15:0]   fault_thr_q, fault_thr_d;
  logic [7:0]    reaction_q, reaction_d;
  logic [15:0]   rdata_q, rdata_d;
  logic          rvalid_q, rvalid_d;
  logic          err_q, err_d;
  logic          warn_q, warn_d;
  logic          fault_q, fault_d;
  logic          pwr_q, pwr_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [2:0]    att_q, att_d;
  logic [2:0]    sync_q;
  logic          ctrl_q, ctrl_d;

  logic [1:0]    resp;
  logic [2:0]    retry;
  logic [2:0]    delay_n;
  logic [CW-1:0] delay_len;
  logic          below_warn;
  logic          below_fault;
  logic          on_cmd;
  logic          clr_any;
  logic          wr_hit;

  assign resp      = reaction_q[cold_guard_pkg::RESP_MSB:cold_guard_pkg::RESP_LSB];
  assign retry     = reaction_q[cold_guard_pkg::RETRY_MSB:cold_guard_pkg::RETRY_LSB];
  assign delay_n   = reaction_q[cold_guard_pkg::DELAY_MSB:cold_guard_pkg::DELAY_LSB];
  assign delay_len = CW'(UNIT_CYCLES) << delay_n;
  assign below_warn  = $signed(temp_i) < $signed(warn_thr_q);
  assign below_fault = $signed(temp_i) < $signed(fault_thr_q);
  assign on_cmd  = ctrl_q & operation_on_i;
  assign clr_any = clear_faults_i | clear_status_i;
  assign wr_hit  = cmd_valid_i & cmd_write_i;

  // Pin synchroniser: a change counts once stages two and three agree
  always_comb begin
    ctrl_d = ctrl_q;
    if (sync_q[1] == sync_q[2]) begin
      ctrl_d = sync_q[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_q <= 3'h0;
      ctrl_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], ctrl_pin_i};
      ctrl_q <= ctrl_d;
    end
  end

  // Register access over the management command port
  always_comb begin
    warn_thr_d  = warn_thr_q;
    fault_thr_d = fault_thr_q;
    reaction_d  = reaction_q;
    rdata_d     = rdata_q;
    rvalid_d    = 1'b0;
    err_d       = 1'b0;
    if (cmd_valid_i) begin
      case (cmd_code_i)
        cold_guard_pkg::CODE_WARN_THR: begin
          if (cmd_write_i) warn_thr_d = cmd_wdata_i;
          rdata_d = warn_thr_q;
        end
        cold_guard_pkg::CODE_FAULT_THR: begin
          if (cmd_write_i) fault_thr_d = cmd_wdata_i;
          rdata_d = fault_thr_q;
        end
        cold_guard_pkg::CODE_REACTION: begin
          if (cmd_write_i) reaction_d = cmd_wdata_i[7:0];
          rdata_d = {8'h00, reaction_q};
        end
        default: begin
          rdata_d = 16'h0000;
          err_d   = 1'b1;
        end
      endcase
      if (!cmd_write_i) rvalid_d = 1'b1;
      else rdata_d = rdata_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      warn_thr_q  <= cold_guard_pkg::WARN_THR_RST;
      fault_thr_q <= cold_guard_pkg::FAULT_THR_RST;
      reaction_q  <= cold_guard_pkg::REACTION_RST;
      rdata_q     <= 16'h0000;
      rvalid_q    <= 1'b0;
      err_q       <= 1'b0;
    end else begin
      warn_thr_q  <= warn_thr_d;
      fault_thr_q <= fault_thr_d;
      reaction_q  <= reaction_d;
      rdata_q     <= rdata_d;
      rvalid_q    <= rvalid_d;
      err_q       <= err_d;
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_comb begin
    warn_d  = (warn_q & ~clr_any) | below_warn;
    fault_d = (fault_q & ~clr_any) | below_fault;
  end

  // Fault reaction sequencer
  always_comb begin
    state_d = state_q;
    cnt_d   = (cnt_q != '0) ? cnt_q - CW'(1) : cnt_q;
    att_d   = att_q;
    if (!on_cmd) begin
      state_d = cold_guard_pkg::ST_STANDBY;
      att_d   = 3'h0;
    end else begin
      case (state_q)
        cold_guard_pkg::ST_RUN: begin
          att_d = 3'h0;
          if (below_fault) begin
            case (resp)
              cold_guard_pkg::RESP_IGNORE: state_d = cold_guard_pkg::ST_RUN;
              cold_guard_pkg::RESP_RUN_ON: begin
                state_d = cold_guard_pkg::ST_HOLD;
                cnt_d   = delay_len - CW'(1);
              end
              cold_guard_pkg::RESP_DISABLE: begin
                state_d = cold_guard_pkg::ST_OFFWAIT;
                cnt_d   = delay_len - CW'(1);
              end
              default: state_d = cold_guard_pkg::ST_LATCHED;
            endcase
          end
        end
        cold_guard_pkg::ST_HOLD: begin
          if (cnt_q == '0) begin
            if (below_fault) begin
              state_d = cold_guard_pkg::ST_OFFWAIT;
              cnt_d   = delay_len - CW'(1);
            end else begin
              state_d = cold_guard_pkg::ST_RUN;
            end
          end
        end
        cold_guard_pkg::ST_OFFWAIT: begin
          if (retry == cold_guard_pkg::RETRY_NONE) begin
            state_d = cold_guard_pkg::ST_LATCHED;
          end else if (cnt_q == '0) begin
            state_d = cold_guard_pkg::ST_TRY;
            if (retry != cold_guard_pkg::RETRY_FOREVER) att_d = att_q + 3'h1;
          end
        end
        cold_guard_pkg::ST_TRY: begin
          if (!below_fault) begin
            state_d = cold_guard_pkg::ST_RUN;
          end else if (retry != cold_guard_pkg::RETRY_FOREVER && att_q >= retry) begin
            state_d = cold_guard_pkg::ST_LATCHED;
          end else begin
            state_d = cold_guard_pkg::ST_OFFWAIT;
            cnt_d   = delay_len - CW'(1) - CW'(1);
          end
        end
        cold_guard_pkg::ST_LATCHED: begin
          if (clr_any) state_d = cold_guard_pkg::ST_RUN;
        end
        cold_guard_pkg::ST_STANDBY: begin
          state_d = cold_guard_pkg::ST_RUN;
        end
        default: state_d = cold_guard_pkg::ST_STANDBY;
      endcase
    end
    pwr_d = (state_d == cold_guard_pkg::ST_RUN) || (state_d == cold_guard_pkg::ST_HOLD) ||
            (state_d == cold_guard_pkg::ST_TRY);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= cold_guard_pkg::ST_STANDBY;
      cnt_q   <= '0;
      att_q   <= 3'h0;
      pwr_q   <= 1'b0;
      warn_q  <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      att_q   <= att_d;
      pwr_q   <= pwr_d;
      warn_q  <= warn_d;
      fault_q <= fault_d;
    end
  end

  assign rdata_o        = rdata_q;
  assign rvalid_o       = rvalid_q;
  assign cmd_err_o      = err_q;
  assign power_enable_o = pwr_q;
  assign warn_flag_o    = warn_q;
  assign fault_flag_o   = fault_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_rd_warn;
    cmd_valid_i && !cmd_write_i && cmd_code_i == cold_guard_pkg::CODE_WARN_THR;
  endsequence
  sequence s_wr_fault;
    wr_hit && cmd_code_i == cold_guard_pkg::CODE_FAULT_THR;
  endsequence
  sequence s_rd_fault;
    cmd_valid_i && !cmd_write_i && cmd_code_i == cold_guard_pkg::CODE_FAULT_THR;
  endsequence

  AST_RD_WARN: assert property (s_rd_warn |=> rvalid_o && rdata_o == warn_thr_q)
    else $error("warning threshold read mismatch");
  AST_WR_FAULT: assert property (s_wr_fault ##1 s_rd_fault |=> rdata_o == $past(cmd_wdata_i, 2))
    else $error("fault threshold write not read back");
  AST_RD_REACT: assert property (cmd_valid_i && !cmd_write_i
                                 && cmd_code_i == cold_guard_pkg::CODE_REACTION
                                 |=> rdata_o == {8'h00, reaction_q})
    else $error("reaction register read mismatch");
  AST_IGNORE: assert property (state_q == cold_guard_pkg::ST_RUN && on_cmd
                               && resp == cold_guard_pkg::RESP_IGNORE |=> power_enable_o)
    else $error("ignore mode dropped the output");
  AST_HOLD_END: assert property (state_q == cold_guard_pkg::ST_HOLD && cnt_q == '0 && below_fault
                                 && on_cmd |=> state_q == cold_guard_pkg::ST_OFFWAIT
                                 && !power_enable_o)
    else $error("persisting fault after delay not acted on");
  AST_DISABLE: assert property (state_q == cold_guard_pkg::ST_RUN && below_fault && on_cmd
                                && resp == cold_guard_pkg::RESP_DISABLE |=> !power_enable_o)
    else $error("disable mode kept the output on");
  AST_LATCH: assert property (state_q == cold_guard_pkg::ST_LATCHED && on_cmd && !clr_any
                              |=> state_q == cold_guard_pkg::ST_LATCHED && !power_enable_o)
    else $error("latched fault released without a clear");
  AST_OFF_ON: assert property (!on_cmd ##1 on_cmd |=> state_q == cold_guard_pkg::ST_RUN)
    else $error("off then on did not clear the fault");
  AST_NO_RETRY: assert property (state_q == cold_guard_pkg::ST_OFFWAIT && on_cmd
                                 && retry == cold_guard_pkg::RETRY_NONE
                                 |=> state_q == cold_guard_pkg::ST_LATCHED)
    else $error("retry zero made a restart");
  AST_GIVE_UP: assert property (state_q == cold_guard_pkg::ST_TRY && below_fault && on_cmd
                                && retry != cold_guard_pkg::RETRY_FOREVER && att_q >= retry
                                |=> state_q == cold_guard_pkg::ST_LATCHED)
    else $error("retries not exhausted correctly");
  AST_SPACING: assert property (state_q != cold_guard_pkg::ST_OFFWAIT
                                && state_d == cold_guard_pkg::ST_OFFWAIT && state_q != cold_guard_pkg::ST_TRY
                                |=> cnt_q == delay_len - CW'(1))
    else $error("restart spacing loaded wrongly");
  AST_FOREVER: assert property (state_q == cold_guard_pkg::ST_TRY && below_fault && on_cmd
                                && retry == cold_guard_pkg::RETRY_FOREVER
                                |=> state_q == cold_guard_pkg::ST_OFFWAIT)
    else $error("continuous retry stopped");
  AST_FAULT_FLAG: assert property (below_fault |=> fault_flag_o)
    else $error("fault flag not set");
  AST_WARN_FLAG: assert property (below_warn |=> warn_flag_o)
    else $error("warning flag not set");

endmodule : cold_guard

/* core/cold_guard_pkg.sv */
package cold_guard_pkg;

  // Command codes on the management port
  localparam logic [7:0] CODE_WARN_THR  = 8'h52;
  localparam logic [7:0] CODE_FAULT_THR = 8'h53;
  localparam logic [7:0] CODE_REACTION  = 8'h54;

  // Reaction register fields
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  localparam logic [1:0] RESP_IGNORE  = 2'h0;
  localparam logic [1:0] RESP_RUN_ON  = 2'h1;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [1:0] RESP_LATCH   = 2'h3;

  localparam logic [2:0] RETRY_NONE   = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Reset values
  localparam logic [15:0] WARN_THR_RST  = 16'h0000;
  localparam logic [15:0] FAULT_THR_RST = 16'h0000;
  localparam logic [7:0]  REACTION_RST  = 8'h00;

  // Timing: one delay unit, derived from the 200 MHz clock
  localparam int CLK_PERIOD_PS = 5000;
  localparam int UNIT_TIME_NS  = 1000;
  localparam int UNIT_CYCLES   = (UNIT_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int MAX_UNITS     = 128;

  typedef enum logic [2:0] {
    ST_RUN     = 3'h0,
    ST_HOLD    = 3'h1,
    ST_OFFWAIT = 3'h3,
    ST_TRY     = 3'h2,
    ST_LATCHED = 3'h6,
    ST_STANDBY = 3'h7
  } guard_state_t;

endpackage : cold_guard_pkg

/* bench/pmbus_host_model.sv */
`timescale 1ns/1ps
module pmbus_host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  input  wire logic        cmd_err_i,
  output logic             cmd_valid_o,
  output logic             cmd_write_o,
  output logic [7:0]       cmd_code_o,
  output logic [15:0]      cmd_wdata_o,
  output logic             clear_faults_o,
  output logic             operation_on_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 16'h0000;
    clear_faults_o = 1'b0;
    operation_on_o = 1'b0;
  end
  // One command per call; lines turn to junk between commands
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ok, output logic err);
    @(negedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= wr;
    cmd_code_o <= code;
    cmd_wdata_o <= wd;
    @(negedge clk_i);
    rd = rdata_i;
    ok = rvalid_i;
    err = cmd_err_i;
    cmd_valid_o <= 1'b0;
    cmd_write_o <= ~wr;
    cmd_code_o <= ~code;
    cmd_wdata_o <= ~wd;
  endtask : xfer
  // Write a code, then read it back on the very next edge
  task automatic wr_rd(input logic [7:0] code, input logic [15:0] wd,
                       output logic [15:0] rd, output logic ok);
    @(negedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= 1'b1;
    cmd_code_o <= code;
    cmd_wdata_o <= wd;
    @(negedge clk_i);
    cmd_write_o <= 1'b0;
    @(negedge clk_i);
    rd = rdata_i;
    ok = rvalid_i;
    cmd_valid_o <= 1'b0;
  endtask : wr_rd
  task automatic clear_all();
    @(negedge clk_i);
    clear_faults_o <= 1'b1;
    @(negedge clk_i);
    clear_faults_o <= 1'b0;
  endtask : clear_all
  task automatic set_on(input logic v);
    @(negedge clk_i);
    operation_on_o <= v;
  endtask : set_on
endmodule : pmbus_host_model

/* bench/under_temp_fault_response_tb_top.sv */
`timescale 1ns/1ps
module under_temp_fault_response_tb_top;
  localparam int U = 2;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        clear_status_i = 1'b0;
  logic        ctrl_pin_i = 1'b1;
  logic [15:0] temp_i = 16'h0064;
  logic        cv, cw, cf, op, rvalid_o, cmd_err_o, power_enable_o, warn_flag_o, fault_flag_o;
  logic [7:0]  cc;
  logic [15:0] wd, rdata_o;
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          rises, gap, g0, t;
  logic [15:0] rb;
  logic        rok, rerr;
  always #2.5 clk_i = ~clk_i;
  cold_guard #(.UNIT_CYCLES(U)) u_cold_guard (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_code_i(cc),
    .cmd_wdata_i(wd), .clear_faults_i(cf), .clear_status_i(clear_status_i),
    .ctrl_pin_i(ctrl_pin_i), .operation_on_i(op), .temp_i(temp_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .cmd_err_o(cmd_err_o), .power_enable_o(power_enable_o),
    .warn_flag_o(warn_flag_o), .fault_flag_o(fault_flag_o));
  pmbus_host_model u_pmbus_host_model (
    .clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .cmd_err_i(cmd_err_o),
    .cmd_valid_o(cv), .cmd_write_o(cw), .cmd_code_o(cc), .cmd_wdata_o(wd),
    .clear_faults_o(cf), .operation_on_o(op));
  task automatic results();
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %0t got %b expected %b", $time, got, exp);
      errors++;
    end
  endtask : chk
  task automatic chkw(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : chkw
  task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic eerr);
    logic [15:0] d;
    logic        ok, err;
    u_pmbus_host_model.xfer(1'b0, code, 16'h0000, d, ok, err);
    chkw(d, exp);
    chk(ok, 1'b1);
    chk(err, eerr);
  endtask : rd
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    logic [15:0] d;
    logic        ok, err;
    u_pmbus_host_model.xfer(1'b1, code, data, d, ok, err);
    chk(ok, 1'b0);
    chk(err, 1'b0);
  endtask : wr
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cycles
  // Restart from a clean running state, program the reaction, then apply temperature
  task automatic arm(input logic [7:0] react, input logic [15:0] tf);
    temp_i = 16'h0064;
    u_pmbus_host_model.set_on(1'b0);
    cycles(3);
    u_pmbus_host_model.set_on(1'b1);
    u_pmbus_host_model.clear_all();
    for (int i = 0; i < 20 && power_enable_o !== 1'b1; i++) @(negedge clk_i);
    chk(power_enable_o, 1'b1);
    wr(cold_guard_pkg::CODE_REACTION, {8'h00, react});
    temp_i = tf;
  endtask : arm
  // Count output restarts and the spacing of the first two
  task automatic watch(input int n);
    int first;
    logic prev;
    rises = 0;
    first = 0;
    gap = 0;
    prev = power_enable_o;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      if (power_enable_o === 1'b1 && prev === 1'b0) begin
        rises++;
        if (rises == 1) first = i;
        if (rises == 2) gap = i - first;
      end
      prev = power_enable_o;
    end
  endtask : watch
  task automatic relatch();
    temp_i = 16'hfffb;
    cycles(4);
    temp_i = 16'h0064;
    cycles(4);
    chk(power_enable_o, 1'b0);
  endtask : relatch
  initial begin
    cycles(12);
    rst_n_i = 1'b1;
    rd(cold_guard_pkg::CODE_WARN_THR, 16'h0000, 1'b0);
    rd(cold_guard_pkg::CODE_FAULT_THR, 16'h0000, 1'b0);
    rd(cold_guard_pkg::CODE_REACTION, 16'h0000, 1'b0);
    rd(8'h55, 16'h0000, 1'b1);
    wr(cold_guard_pkg::CODE_WARN_THR, 16'h000a);
    u_pmbus_host_model.wr_rd(cold_guard_pkg::CODE_FAULT_THR, 16'h8001, rb, rok);
    chkw(rb, 16'h8001);
    chk(rok, 1'b1);
    wr(cold_guard_pkg::CODE_REACTION, 16'hff3c);
    // Unknown code: write refused with an error pulse and no read answer
    u_pmbus_host_model.xfer(1'b1, 8'h55, 16'h00c3, rb, rok, rerr);
    chk(rok, 1'b0);
    chk(rerr, 1'b1);
    rd(cold_guard_pkg::CODE_WARN_THR, 16'h000a, 1'b0);
    rd(cold_guard_pkg::CODE_FAULT_THR, 16'h8001, 1'b0);
    rd(cold_guard_pkg::CODE_REACTION, 16'h003c, 1'b0);
    wr(cold_guard_pkg::CODE_FAULT_THR, 16'h0000);
    arm(8'h00, 16'h0005);
    cycles(3);
    chk(warn_flag_o, 1'b1);
    chk(fault_flag_o, 1'b0);
    chk(power_enable_o, 1'b1);
    arm(8'h00, 16'hfffb);
    watch(40);
    chk(fault_flag_o, 1'b1);
    chk(power_enable_o, 1'b1);
    for (int r = 0; r < 8; r++) begin
      arm({2'b10, r[2:0], 3'h0}, 16'hfffb);
      watch(200);
      if (r < 7) begin
        chkw(rises[15:0], r[15:0]);
        chk(power_enable_o, 1'b0);
      end else begin
        chk(rises > 6, 1'b1);
      end
    end
    u_pmbus_host_model.set_on(1'b0);
    cycles(3);
    chk(power_enable_o, 1'b0);
    arm(8'hb8, 16'hfffb);
    watch(200);
    g0 = gap;
    arm(8'hbb, 16'hfffb);
    watch(200);
    chkw(16'(gap - g0), 16'(U * 7));
    arm(8'h43, 16'hfffb);
    for (t = 0; t < 100 && power_enable_o === 1'b1; t++) @(negedge clk_i);
    chk(t >= U * 8 && t <= U * 8 + 3, 1'b1);
    watch(60);
    chkw(rises[15:0], 16'h0000);
    chk(power_enable_o, 1'b0);
    arm(8'hc0, 16'hfffb);
    cycles(4);
    temp_i = 16'h0064;
    cycles(8);
    chk(power_enable_o, 1'b0);
    clear_status_i = 1'b1;
    cycles(1);
    clear_status_i = 1'b0;
    cycles(4);
    chk(power_enable_o, 1'b1);
    chk(fault_flag_o, 1'b0);
    relatch();
    u_pmbus_host_model.clear_all();
    cycles(4);
    chk(power_enable_o, 1'b1);
    relatch();
    ctrl_pin_i = 1'b0;
    cycles(6);
    ctrl_pin_i = 1'b1;
    cycles(8);
    chk(power_enable_o, 1'b1);
    relatch();
    rst_n_i = 1'b0;
    cycles(3);
    chk(power_enable_o, 1'b0);
    rst_n_i = 1'b1;
    rd(cold_guard_pkg::CODE_REACTION, 16'h0000, 1'b0);
    results();
  end
endmodule : under_temp_fault_response_tb_top
